// *** daap_acc_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface daap_acc_if;
   logic req;
   logic wr;
   logic ext;
   logic [10:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic err;
   logic [3:0] waitStates;
   modport engine (output req, wr, ext, addr, wdata, input rdata, err, waitStates);
   modport regs (input req, wr, ext, addr, wdata, output rdata, err, waitStates);
endinterface
`default_nettype wire

// *** daap_apb_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
module daap_apb_engine (
   input wire logic clk,                              // Processor clock
   input wire logic arst_n,                           // Async reset, active low
   input wire logic dbgport_select,                   // Debug registers selected
   input wire logic dbgport_phase_enable,             // Access phase marker
   input wire logic dbgport_direction,                // 1 write, 0 read
   input wire logic [10:0] dbgport_word_addr,         // Word address
   input wire logic external_debugger_access_flag,    // Access from external debugger
   input wire logic [31:0] dbgport_write_bus,         // Write data
   output logic [31:0] dbgport_read_bus,              // Read data, registered
   output logic dbgport_ready,                        // Transfer complete
   output logic dbgport_error,                        // Transfer failed, registered
   daap_acc_if.engine acc                             // Access to the register file
);
   daap_pkg::daap_eng_state_t state_reg;
   logic [3:0] waitCnt_reg;

   assign acc.wr = dbgport_direction;
   assign acc.ext = external_debugger_access_flag;    // [RULE3]
   assign acc.addr = dbgport_word_addr;               // [RULE8]
   assign acc.wdata = dbgport_write_bus;
   // One access per transfer, fired once the programmed wait states are spent
   assign acc.req = (state_reg == daap_pkg::ENG_WAIT) && dbgport_select &&
                    (waitCnt_reg == 4'h0);            // [RULE5]
   // Ready only in the access phase, after the setup cycle  [RULE4] [RULE6]
   assign dbgport_ready = (state_reg == daap_pkg::ENG_RESP) && dbgport_select &&
                          dbgport_phase_enable;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= daap_pkg::ENG_IDLE;
         waitCnt_reg <= 4'h0;
      end else begin
         case (state_reg)
            daap_pkg::ENG_IDLE: begin
               if (dbgport_select && !dbgport_phase_enable) begin   // [RULE5] [RULE8]
                  state_reg <= daap_pkg::ENG_WAIT;
                  waitCnt_reg <= acc.waitStates;                    // [RULE6]
               end
            end
            daap_pkg::ENG_WAIT: begin
               if (!dbgport_select) begin
                  state_reg <= daap_pkg::ENG_IDLE;
               end else if (waitCnt_reg == 4'h0) begin
                  state_reg <= daap_pkg::ENG_RESP;
               end else begin
                  waitCnt_reg <= waitCnt_reg - 4'h1;                // [RULE6]
               end
            end
            daap_pkg::ENG_RESP: begin
               if (!dbgport_select || dbgport_phase_enable) begin
                  state_reg <= daap_pkg::ENG_IDLE;
               end
            end
            default: begin
               state_reg <= daap_pkg::ENG_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Response captured at the access so it stands still while ready is high
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dbgport_read_bus <= 32'h0000_0000;
         dbgport_error <= 1'b0;
      end else if (acc.req) begin
         dbgport_read_bus <= (acc.wr || acc.err) ? 32'h0000_0000 : acc.rdata;  // [RULE8]
         dbgport_error <= acc.err;                                            // [RULE7]
      end
   end
endmodule
`default_nettype wire

// *** daap_cfg.svh ***
`ifndef DAAP_CFG_SVH
`define DAAP_CFG_SVH

// Register offsets on the AXI4-Lite side
`define DAAP_CTRL_OFFS 12'h000
`define DAAP_STATUS_OFFS 12'h004
`define DAAP_IRQ_STAT_OFFS 12'h008
`define DAAP_IRQ_MASK_OFFS 12'h00C
`define DAAP_XFER_CNT_OFFS 12'h010

// CTRL fields
`define DAAP_CTRL_WAIT_LSB 0
`define DAAP_CTRL_WAIT_W 4
`define DAAP_CTRL_EXTONLY_BIT 4
`define DAAP_CTRL_W 5
`define DAAP_CTRL_RST 5'h00

// STATUS fields: permits in bits 3:0, last access origin above them
`define DAAP_PERMIT_INV_BIT 0
`define DAAP_PERMIT_NONINV_BIT 1
`define DAAP_PERMIT_SECINV_BIT 2
`define DAAP_PERMIT_SECNONINV_BIT 3
`define DAAP_STATUS_LASTEXT_BIT 4

// Event bits, shared by IRQ status and mask
`define DAAP_EV_EXT_BIT 0
`define DAAP_EV_ERR_BIT 1
`define DAAP_EV_PERMIT_BIT 2
`define DAAP_EV_W 3
`define DAAP_EV_RST 3'h0

// Debug register file
`define DAAP_NUM_DBG_REGS 16
`define DAAP_SECURE_BASE 8
`define DAAP_DBG_REG_RST 32'h0000_0000

`define DAAP_RESP_OKAY 2'h0
`define DAAP_RESP_SLVERR 2'h2

`endif

// *** daap_dbg_requester.sv ***
`timescale 1ns/1ps
`default_nettype none
module daap_dbg_requester (
   input wire logic clk,            // Clock
   output logic sel,                // Select
   output logic phaseEn,            // Access phase
   output logic dir,                // 1 write
   output logic [10:0] wordAddr,    // Word address
   output logic extFlag,            // External debugger access
   output logic [31:0] wData,       // Write data
   input wire logic ready,          // Ready
   input wire logic [31:0] rData,   // Read data
   input wire logic err             // Error
);
   initial begin
      sel = 1'b0;
      phaseEn = 1'b0;
      dir = 1'b0;
      wordAddr = 11'h0;
      extFlag = 1'b0;
      wData = 32'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Ready is looked at mid-cycle so the edge that ends the transfer is never raced
   task automatic xfer(input logic wr, input logic ext, input logic [10:0] a,
         input logic [31:0] d, output logic [31:0] rd, output logic er, output int n);
      n = 0;
      @(posedge clk);
      sel <= 1'b1;
      phaseEn <= 1'b0;
      dir <= wr;
      wordAddr <= a;
      extFlag <= ext;
      wData <= d;
      @(posedge clk);
      phaseEn <= 1'b1;
      do begin
         @(negedge clk);
         n++;
      end while (ready !== 1'b1 && n < 40);
      rd = rData;
      er = err;
      @(posedge clk);
      sel <= 1'b0;
      phaseEn <= 1'b0;
      // Released lines must not keep the last value
      wordAddr <= ~a;
      wData <= ~d;
      dir <= ~wr;
      extFlag <= ~ext;
   endtask
endmodule
`default_nettype wire

// *** daap_debug_port.sv ***
// Contract
// (RULE1) Secure invasive permit: 1 allows secure invasive debug, 0 forbids it.
// (RULE2) Secure non-invasive debug allowed only while its permit input is 1.
// (RULE3) Address bit 31 set marks an external debugger access, clear otherwise.
// (RULE4) Requester raises phase enable from the second transfer cycle onward only.
// (RULE5) Select high addresses the debug registers; device answers only then.
// (RULE6) Device holds ready low for wait states; transfer ends when ready is high.
// (RULE7) Device drives an error output to flag a failed transfer.
// (RULE8) Standard setup and access phases, word address 12:2, split 32-bit buses.
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "daap_cfg.svh"
module daap_debug_port #(
   parameter int NUM_DBG_REGS = `DAAP_NUM_DBG_REGS,   // Debug words behind the port
   parameter int SECURE_BASE = `DAAP_SECURE_BASE      // First secure debug word
) (
   input wire logic clk,                              // Processor clock, 100 MHz
   input wire logic arst_n,                           // Async reset, active low
   input wire logic invasive_debug_permit,            // From security controller
   input wire logic noninvasive_debug_permit,         // From security controller
   input wire logic secure_invasive_debug_permit,     // From security controller
   input wire logic secure_noninvasive_debug_permit,  // From security controller
   input wire logic dbgport_select,                   // Debug registers selected
   input wire logic dbgport_phase_enable,             // Access phase marker
   input wire logic dbgport_direction,                // 1 write, 0 read
   input wire logic [10:0] dbgport_word_addr,         // Word address
   input wire logic external_debugger_access_flag,    // Address bit 31
   input wire logic [31:0] dbgport_write_bus,         // Write data
   output logic [31:0] dbgport_read_bus,              // Read data
   output logic dbgport_ready,                        // Transfer complete
   output logic dbgport_error,                        // Transfer failed
   input wire logic [11:0] s_axi_awaddr,              // AXI write address
   input wire logic s_axi_awvalid,                    // AXI write address valid
   output logic s_axi_awready,                        // AXI write address ready
   input wire logic [31:0] s_axi_wdata,               // AXI write data
   input wire logic [3:0] s_axi_wstrb,                // AXI byte strobes
   input wire logic s_axi_wvalid,                     // AXI write data valid
   output logic s_axi_wready,                         // AXI write data ready
   output logic [1:0] s_axi_bresp,                    // AXI write response
   output logic s_axi_bvalid,                         // AXI write response valid
   input wire logic s_axi_bready,                     // AXI write response ready
   input wire logic [11:0] s_axi_araddr,              // AXI read address
   input wire logic s_axi_arvalid,                    // AXI read address valid
   output logic s_axi_arready,                        // AXI read address ready
   output logic [31:0] s_axi_rdata,                   // AXI read data
   output logic [1:0] s_axi_rresp,                    // AXI read response
   output logic s_axi_rvalid,                         // AXI read valid
   input wire logic s_axi_rready,                     // AXI read ready
   output logic irq                                   // Level interrupt
);
   localparam int IDX_W = $clog2(NUM_DBG_REGS);

   generate
      if (NUM_DBG_REGS < 2 || NUM_DBG_REGS > 2048 || SECURE_BASE < 0 ||
          SECURE_BASE > NUM_DBG_REGS) begin : g_bad_cfg
         $error("daap_debug_port: unsupported register file size");
      end
   endgenerate

   daap_acc_if acc ();

   logic [3:0] permitMeta_reg;
   logic [3:0] permitSync_reg;
   logic [3:0] permitPrev_reg;
   logic [`DAAP_CTRL_W-1:0] ctrl_reg;
   logic [`DAAP_EV_W-1:0] irqStat_reg;
   logic [`DAAP_EV_W-1:0] irqMask_reg;
   logic [`DAAP_EV_W-1:0] events;
   logic lastExt_reg;
   logic [31:0] xferCnt_reg;
   logic [31:0] dbgRegs [NUM_DBG_REGS];
   logic inRange;
   logic secureReg;
   logic allowed;
   logic [IDX_W-1:0] idx;

   daap_apb_engine u_engine (
      .clk(clk),
      .arst_n(arst_n),
      .dbgport_select(dbgport_select),
      .dbgport_phase_enable(dbgport_phase_enable),
      .dbgport_direction(dbgport_direction),
      .dbgport_word_addr(dbgport_word_addr),
      .external_debugger_access_flag(external_debugger_access_flag),
      .dbgport_write_bus(dbgport_write_bus),
      .dbgport_read_bus(dbgport_read_bus),
      .dbgport_ready(dbgport_ready),
      .dbgport_error(dbgport_error),
      .acc(acc.engine)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Permit levels come from another controller, so two flops before use
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         permitMeta_reg <= 4'h0;
         permitSync_reg <= 4'h0;
         permitPrev_reg <= 4'h0;
      end else begin
         permitMeta_reg <= {secure_noninvasive_debug_permit, secure_invasive_debug_permit,
                            noninvasive_debug_permit, invasive_debug_permit};
         permitSync_reg <= permitMeta_reg;
         permitPrev_reg <= permitSync_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Access check; secure words need the secure permit on top of the base one
   assign idx = acc.addr[IDX_W-1:0];
   // One spare bit so a full 2048-word file or an empty secure range still compares right
   assign inRange = {1'b0, acc.addr} < 12'(NUM_DBG_REGS);
   assign secureReg = {1'b0, acc.addr} >= 12'(SECURE_BASE);
   assign acc.waitStates = ctrl_reg[`DAAP_CTRL_WAIT_LSB +: `DAAP_CTRL_WAIT_W];

   always_comb begin
      if (acc.wr) begin
         allowed = permitSync_reg[`DAAP_PERMIT_INV_BIT] &&
                   (!secureReg || permitSync_reg[`DAAP_PERMIT_SECINV_BIT]);   // [RULE1]
      end else begin
         allowed = (permitSync_reg[`DAAP_PERMIT_INV_BIT] ||
                    permitSync_reg[`DAAP_PERMIT_NONINV_BIT]) &&
                   (!secureReg || permitSync_reg[`DAAP_PERMIT_SECNONINV_BIT]); // [RULE2]
      end
   end

   // External-only mode refuses anything not flagged as a debugger access
   assign acc.err = !inRange || !allowed ||
                    (ctrl_reg[`DAAP_CTRL_EXTONLY_BIT] && !acc.ext);          // [RULE3] [RULE7]
   assign acc.rdata = inRange ? dbgRegs[idx] : 32'h0000_0000;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NUM_DBG_REGS; i++) begin
            dbgRegs[i] <= `DAAP_DBG_REG_RST;
         end
      end else if (acc.req && acc.wr && !acc.err) begin
         dbgRegs[idx] <= acc.wdata;                                         // [RULE8]
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lastExt_reg <= 1'b0;
         xferCnt_reg <= 32'h0000_0000;
      end else if (acc.req) begin
         lastExt_reg <= acc.ext;
         xferCnt_reg <= xferCnt_reg + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave: address and data held separately, answered together
   logic awHeld_reg;
   logic wHeld_reg;
   logic [11:0] awAddr_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;
   logic doWrite;
   logic wrMapped;
   logic [31:0] strbData;
   logic [31:0] rdMux;
   logic rdMapped;

   assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         strbData[8*b +: 8] = wStrb_reg[b] ? wData_reg[8*b +: 8] : 8'h00;
      end
   end

   always_comb begin
      wrMapped = 1'b1;
      case (awAddr_reg)
         `DAAP_CTRL_OFFS, `DAAP_STATUS_OFFS, `DAAP_IRQ_STAT_OFFS,
         `DAAP_IRQ_MASK_OFFS, `DAAP_XFER_CNT_OFFS: wrMapped = 1'b1;
         default: wrMapped = 1'b0;
      endcase
   end

   always_comb begin
      rdMapped = 1'b1;
      rdMux = 32'h0000_0000;
      case (s_axi_araddr)
         `DAAP_CTRL_OFFS: rdMux[`DAAP_CTRL_W-1:0] = ctrl_reg;
         `DAAP_STATUS_OFFS: rdMux[4:0] = {lastExt_reg, permitSync_reg};
         `DAAP_IRQ_STAT_OFFS: rdMux[`DAAP_EV_W-1:0] = irqStat_reg;
         `DAAP_IRQ_MASK_OFFS: rdMux[`DAAP_EV_W-1:0] = irqMask_reg;
         `DAAP_XFER_CNT_OFFS: rdMux = xferCnt_reg;
         default: rdMapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= 12'h000;
         wData_reg <= 32'h0000_0000;
         wStrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DAAP_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? `DAAP_RESP_OKAY : `DAAP_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `DAAP_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdMux;
         s_axi_rresp <= rdMapped ? `DAAP_RESP_OKAY : `DAAP_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and interrupt registers; byte 0 holds every writable field
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= `DAAP_CTRL_RST;
         irqMask_reg <= `DAAP_EV_RST;
      end else if (doWrite) begin
         if (awAddr_reg == `DAAP_CTRL_OFFS && wStrb_reg[0]) begin
            ctrl_reg <= strbData[`DAAP_CTRL_W-1:0];
         end
         if (awAddr_reg == `DAAP_IRQ_MASK_OFFS && wStrb_reg[0]) begin
            irqMask_reg <= strbData[`DAAP_EV_W-1:0];
         end
      end
   end

   always_comb begin
      events = '0;
      events[`DAAP_EV_EXT_BIT] = acc.req && acc.ext && !acc.err;
      events[`DAAP_EV_ERR_BIT] = acc.req && acc.err;                        // [RULE7]
      events[`DAAP_EV_PERMIT_BIT] = permitSync_reg != permitPrev_reg;
   end

   // A new event outranks a clear landing in the same cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irqStat_reg <= `DAAP_EV_RST;
      end else if (doWrite && awAddr_reg == `DAAP_IRQ_STAT_OFFS) begin
         irqStat_reg <= (irqStat_reg & ~strbData[`DAAP_EV_W-1:0]) | events;
      end else begin
         irqStat_reg <= irqStat_reg | events;
      end
   end

   assign irq = |(irqStat_reg & irqMask_reg);
endmodule
`default_nettype wire

// *** daap_debug_port_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module daap_debug_port_chk (
   input wire logic clk,                      // Clock
   input wire logic arst_n,                   // Reset, active low
   input wire logic dbgport_select,           // Select
   input wire logic dbgport_phase_enable,     // Access phase
   input wire logic dbgport_ready,            // Ready
   input wire logic dbgport_error,            // Error
   input wire logic [31:0] dbgport_read_bus,  // Read data
   input wire logic s_axi_arready,            // Read address ready
   input wire logic s_axi_bvalid,             // Write response valid
   input wire logic s_axi_bready,             // Write response ready
   input wire logic [1:0] s_axi_bresp,        // Write response
   input wire logic s_axi_rvalid,             // Read valid
   input wire logic s_axi_rready,             // Read ready
   input wire logic [31:0] s_axi_rdata        // Read data
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   logic acc;
   assign acc = dbgport_select && dbgport_phase_enable;
   chk_ready_needs_acc: assert property (dbgport_ready |-> acc)
      else $error("ready outside an access phase");
   chk_first_cycle_waits: assert property (
      dbgport_select && $rose(dbgport_phase_enable) |-> !dbgport_ready)
      else $error("ready in first access cycle");
   chk_wait_bounded: assert property (
      dbgport_select && $rose(dbgport_phase_enable) |-> ##[1:16] (dbgport_ready || !acc))
      else $error("ready later than seventeen access cycles");
   chk_ready_pulse: assert property (dbgport_ready |=> !dbgport_ready)
      else $error("ready longer than one cycle");
   chk_err_no_data: assert property (
      dbgport_ready && dbgport_error |-> dbgport_read_bus == 32'h0)
      else $error("data returned with error");
   chk_result_holds: assert property (
      !acc |=> $stable(dbgport_read_bus) && $stable(dbgport_error))
      else $error("result changed outside access");
   chk_bresp_holds: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_rdata_holds: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_read_one_out: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   cov_err_xfer: cover property (dbgport_ready && dbgport_error);
   cov_ok_xfer: cover property (dbgport_ready && !dbgport_error);
   cov_wr_resp: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind daap_debug_port daap_debug_port_chk daap_debug_port_chk_i (.clk(clk), .arst_n(arst_n),
   .dbgport_select(dbgport_select), .dbgport_phase_enable(dbgport_phase_enable),
   .dbgport_ready(dbgport_ready), .dbgport_error(dbgport_error),
   .dbgport_read_bus(dbgport_read_bus), .s_axi_arready(s_axi_arready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire

// *** daap_debug_port_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "daap_cfg.svh"
module daap_debug_port_tb_top;
   logic clk, arst_n, irq, invasive_debug_permit, noninvasive_debug_permit;
   logic secure_invasive_debug_permit, secure_noninvasive_debug_permit;
   logic dbgport_select, dbgport_phase_enable, dbgport_direction, external_debugger_access_flag;
   logic [10:0] dbgport_word_addr;
   logic [31:0] dbgport_write_bus, dbgport_read_bus, s_axi_wdata, s_axi_rdata;
   logic dbgport_ready, dbgport_error, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int failCount = 0;
   int nCompared = 0;
   daap_debug_port #(.NUM_DBG_REGS(16), .SECURE_BASE(8)) daap_debug_port_i (.*);
   daap_dbg_requester daap_dbg_requester_i (.clk(clk), .sel(dbgport_select),
      .phaseEn(dbgport_phase_enable), .dir(dbgport_direction), .wordAddr(dbgport_word_addr),
      .extFlag(external_debugger_access_flag), .wData(dbgport_write_bus),
      .ready(dbgport_ready), .rData(dbgport_read_bus), .err(dbgport_error));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic testDone;
      $display("compared %0d mismatches %0d", nCompared, failCount);
      if (failCount == 0 && nCompared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      nCompared++;
      if (got !== exp) begin
         failCount++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wrReg(input logic [11:0] a, input logic [31:0] d,
         input logic [1:0] eb = 2'h0);
      logic ta, tw, bh;
      logic [1:0] r;
      int n;
      n = 0;
      bh = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!bh && n < 50) begin
         @(negedge clk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         bh = s_axi_bvalid;
         r = s_axi_bresp;
         n++;
         @(posedge clk);
         if (ta)
            s_axi_awvalid <= 1'b0;
         if (tw)
            s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk("write response", 32'(eb), 32'(r));
   endtask
   task automatic rdReg(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic ta, rh;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      n = 0;
      rh = 1'b0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!rh && n < 50) begin
         @(negedge clk);
         ta = s_axi_arready;
         rh = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         n++;
         @(posedge clk);
         if (ta)
            s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      chk("read response", 32'(er), 32'(r));
      chk("register value", exp, d);
   endtask
   task automatic dbg(input logic wr, input logic ext, input logic [10:0] a,
         input logic [31:0] d, input logic expErr, input logic [31:0] expRd, input int expN);
      logic [31:0] rd;
      logic er;
      int n;
      daap_dbg_requester_i.xfer(wr, ext, a, d, rd, er, n);
      chk("debug error", 32'(expErr), 32'(er));
      chk("debug read data", expRd, rd);
      chk("access cycles", 32'(expN), 32'(n));
   endtask
   // Permits pass a two-stage synchroniser, so give them time to land
   task automatic setPermits(input logic [3:0] v);
      @(posedge clk);
      {secure_noninvasive_debug_permit, secure_invasive_debug_permit} <= v[3:2];
      {noninvasive_debug_permit, invasive_debug_permit} <= v[1:0];
      repeat (4) @(posedge clk);
   endtask
   task automatic irqIs(input logic exp);
      @(negedge clk);
      chk("interrupt", 32'(exp), 32'(irq));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      arst_n = 1'b0;
      {invasive_debug_permit, noninvasive_debug_permit} = 2'h0;
      {secure_invasive_debug_permit, secure_noninvasive_debug_permit} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      s_axi_wstrb = 4'hF;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      rdReg(`DAAP_CTRL_OFFS, 32'h0, `DAAP_RESP_OKAY);
      rdReg(`DAAP_IRQ_MASK_OFFS, 32'h0, `DAAP_RESP_OKAY);
      rdReg(`DAAP_STATUS_OFFS, 32'h0, `DAAP_RESP_OKAY);
      rdReg(12'h014, 32'h0, `DAAP_RESP_SLVERR);
      wrReg(12'h014, 32'h1, `DAAP_RESP_SLVERR);
      setPermits(4'hF);
      rdReg(`DAAP_STATUS_OFFS, 32'hF, `DAAP_RESP_OKAY);
      rdReg(`DAAP_IRQ_STAT_OFFS, 32'h4, `DAAP_RESP_OKAY);
      wrReg(`DAAP_IRQ_MASK_OFFS, 32'h2);
      wrReg(`DAAP_IRQ_STAT_OFFS, 32'h7);
      rdReg(`DAAP_IRQ_STAT_OFFS, 32'h0, `DAAP_RESP_OKAY);
      dbg(1'b1, 1'b1, 11'h9, 32'hA5A5_1234, 1'b0, 32'h0, 2);
      dbg(1'b0, 1'b1, 11'h9, 32'h0, 1'b0, 32'hA5A5_1234, 2);
      wrReg(`DAAP_STATUS_OFFS, 32'h0);
      rdReg(`DAAP_STATUS_OFFS, 32'h1F, `DAAP_RESP_OKAY);
      rdReg(`DAAP_IRQ_STAT_OFFS, 32'h1, `DAAP_RESP_OKAY);
      irqIs(1'b0);
      rdReg(`DAAP_XFER_CNT_OFFS, 32'h2, `DAAP_RESP_OKAY);
      wrReg(`DAAP_CTRL_OFFS, 32'h3);
      dbg(1'b0, 1'b0, 11'h9, 32'h0, 1'b0, 32'hA5A5_1234, 5);
      rdReg(`DAAP_STATUS_OFFS, 32'hF, `DAAP_RESP_OKAY);
      wrReg(`DAAP_CTRL_OFFS, 32'h10);
      dbg(1'b0, 1'b0, 11'h9, 32'h0, 1'b1, 32'h0, 2);
      irqIs(1'b1);
      wrReg(`DAAP_IRQ_STAT_OFFS, 32'h7);
      irqIs(1'b0);
      wrReg(`DAAP_CTRL_OFFS, 32'h0);
      setPermits(4'hB);
      dbg(1'b1, 1'b1, 11'h9, 32'h1111_2222, 1'b1, 32'h0, 2);
      dbg(1'b0, 1'b1, 11'h9, 32'h0, 1'b0, 32'hA5A5_1234, 2);
      dbg(1'b1, 1'b1, 11'h7, 32'h0000_0777, 1'b0, 32'h0, 2);
      setPermits(4'h7);
      dbg(1'b0, 1'b1, 11'h9, 32'h0, 1'b1, 32'h0, 2);
      dbg(1'b0, 1'b1, 11'h7, 32'h0, 1'b0, 32'h0000_0777, 2);
      dbg(1'b1, 1'b1, 11'h10, 32'h5, 1'b1, 32'h0, 2);
      testDone();
   end
   initial begin
      repeat (20000) @(posedge clk);
      failCount++;
      testDone();
   end
endmodule
`default_nettype wire

// *** daap_pkg.sv ***
package daap_pkg;
   typedef enum logic [1:0] {ENG_IDLE, ENG_WAIT, ENG_RESP} daap_eng_state_t;
endpackage
